// File: hdl/tcsp_defs.svh
// Constants of the Type-C source port status logic.
// Assumes a 20 MHz clock on mclk_i.
`ifndef TCSP_DEFS_SVH
`define TCSP_DEFS_SVH

`define TCSP_CLK_MHZ          20
// Overcurrent deglitch, least time in microseconds
`define TCSP_OC_DEGLITCH_US   8
`define TCSP_OC_DEGLITCH_CYC  ((`TCSP_OC_DEGLITCH_US * `TCSP_CLK_MHZ) + 0)
// Sink attach deglitch, least time in microseconds
`define TCSP_ATT_DEGLITCH_US  100
`define TCSP_ATT_DEGLITCH_CYC (`TCSP_ATT_DEGLITCH_US * `TCSP_CLK_MHZ)
// Thermal restart hysteresis in degrees C
`define TCSP_THERM_HYST_C     20
// Heavy-load threshold in milliamps
`define TCSP_HEAVY_LOAD_MA    1950

`endif

// File: hdl/tcsp_pkg.sv
// Types of the Type-C source port status logic.
// Used by tcsp_port alone through scoped names.
package tcsp_pkg;

    // Decoded termination seen on one CC line
    typedef enum logic [1:0] {
        TCSP_CC_OPEN = 2'h0,
        TCSP_CC_RA   = 2'h1,
        TCSP_CC_RD   = 2'h2
    } tcsp_cc_t;

    // Attach state of the port
    typedef enum logic [2:0] {
        TCSP_ST_IDLE   = 3'h0,
        TCSP_ST_WAIT   = 3'h1,
        TCSP_ST_SINK   = 3'h2,
        TCSP_ST_AUDIO  = 3'h3,
        TCSP_ST_DEBUG  = 3'h4
    } tcsp_att_t;

endpackage

// File: hdl/tcsp_deglitch.sv
// Deglitch filter: output follows input only after it has held steady.
// Input assumed synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none

module tcsp_deglitch #(
    parameter int CYCLES = 160
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Level in and filtered level out
    input  wire logic raw_i,
    output logic      clean_o
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          clean;
    } tcsp_dg_st_t;

    tcsp_dg_st_t st_r;
    tcsp_dg_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (raw_i == st_r.clean) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == CW'(CYCLES - 1)) begin
            st_nxt.cnt   = '0;
            st_nxt.clean = raw_i;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clean_o = st_r.clean;

endmodule

`default_nettype wire

// File: hdl/tcsp_port.sv
// Type-C source port status logic: lockout, enable, fault, attach decode.
// Analog comparators deliver clean synchronous levels; pads resolve OE.
// CC terminations arrive already decoded per line as tcsp_cc_t codes.
//
// Notes on behaviour
// - Main switch off while supply locked out
// - Error flag low on overcurrent or overtemperature
// - Overcurrent deglitched before error flag asserts
// - Low thermal threshold: flag error, switch off
// - High thermal threshold: release outputs, disable
// - Restart only after twenty degree cooling
// - Ra on both lines asserts audio flag
// - Audio flag releases when CC2 Ra gone
// - Rd on both lines asserts debug flag
// - Debug flag releases when CC1 Rd gone
// - Orientation low for Rd on CC2
// - Orientation released without attached sink
// - Enable low: switches off, outputs released
// - Enable high turns the device on
// - Heavy-load flag while current exceeds threshold
// - Sink-attached flag low while sink present
// - Switch after deglitch; cable supply on Ra
`timescale 1ns/1ns
`default_nettype none
`include "tcsp_defs.svh"

module tcsp_port #(
    parameter int OC_DEGLITCH_CYC  = `TCSP_OC_DEGLITCH_CYC,
    parameter int ATT_DEGLITCH_CYC = `TCSP_ATT_DEGLITCH_CYC
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // System control
    input  wire logic       enable_i,
    input  wire logic       supply_lockout_i,
    // Protection sense
    input  wire logic       overcurrent_i,
    input  wire logic       thermal_threshold_low_i,
    input  wire logic       thermal_threshold_high_i,
    input  wire logic       thermal_cooled_i,
    input  wire logic       heavy_load_i,
    // CC line terminations, encoded as tcsp_cc_t
    input  wire logic [1:0] cc1_term_i,
    input  wire logic [1:0] cc2_term_i,
    // Power switches
    output logic            main_switch_on_o,
    output logic            cable_supply_cc1_o,
    output logic            cable_supply_cc2_o,
    output logic            cc_monitor_on_o,
    // Open-drain flags: output tied low, enable high while pulling
    output logic            error_flag_n_o,
    output logic            error_flag_n_oe_o,
    output logic            sink_attached_n_o,
    output logic            sink_attached_n_oe_o,
    output logic            orientation_flag_n_o,
    output logic            orientation_flag_n_oe_o,
    output logic            audio_flag_n_o,
    output logic            audio_flag_n_oe_o,
    output logic            test_flag_n_o,
    output logic            test_flag_n_oe_o,
    output logic            heavy_load_n_o,
    output logic            heavy_load_n_oe_o
);

    localparam int AW = $clog2(ATT_DEGLITCH_CYC + 1);
    // Last count of the attach wait; the switch closes on this sample
    localparam logic [AW-1:0] ATT_LAST = AW'(ATT_DEGLITCH_CYC - 1);

    typedef struct packed {
        // Attach machine
        tcsp_pkg::tcsp_att_t att;
        logic [AW-1:0]       cnt;
        logic                cc2_side;
        // Thermal latches
        logic                thermal_hold;
        logic                shutdown;
        // Registered outputs
        logic                main_on;
        logic                vc1;
        logic                vc2;
        logic                mon;
        logic                err_oe;
        logic                sink_oe;
        logic                orient_oe;
        logic                audio_oe;
        logic                test_oe;
        logic                heavy_oe;
    } tcsp_st_t;

    tcsp_st_t st_r;
    tcsp_st_t st_nxt;

    tcsp_pkg::tcsp_cc_t cc1;
    tcsp_pkg::tcsp_cc_t cc2;
    logic               oc_clean;
    logic               shutdown_nxt;
    logic               active;
    // Decoded CC patterns
    logic               sink_pat;
    logic               audio_pat;
    logic               debug_pat;
    logic               rd_on_cc2;
    logic               side_kept;
    logic               ra_on_cc1;
    logic               ra_on_cc2;

    assign cc1 = tcsp_pkg::tcsp_cc_t'(cc1_term_i);
    assign cc2 = tcsp_pkg::tcsp_cc_t'(cc2_term_i);

    // Short overcurrent spikes never reach the error flag
    tcsp_deglitch #(
        .CYCLES (OC_DEGLITCH_CYC)
    ) u_oc_dg (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (overcurrent_i),
        .clean_o (oc_clean)
    );

    // Shutdown latches at the high threshold and clears only once cooled.
    // Its next value gates the port, so outputs drop on the tripping edge.
    assign shutdown_nxt = thermal_threshold_high_i
                          || (st_r.shutdown && !thermal_cooled_i);

    // Lockout hysteresis lives in the analog comparator; this is its level
    assign active = enable_i && !supply_lockout_i && !shutdown_nxt;

    assign rd_on_cc2 = (cc2 == tcsp_pkg::TCSP_CC_RD);
    assign ra_on_cc1 = (cc1 == tcsp_pkg::TCSP_CC_RA);
    assign ra_on_cc2 = (cc2 == tcsp_pkg::TCSP_CC_RA);
    assign audio_pat = ra_on_cc1 && ra_on_cc2;
    assign debug_pat = (cc1 == tcsp_pkg::TCSP_CC_RD) && rd_on_cc2;
    // Exactly one line carries Rd and the other is not Rd
    assign sink_pat  = (cc1 == tcsp_pkg::TCSP_CC_RD) != rd_on_cc2;
    // Rd has stayed on the line where the attach began
    assign side_kept = (rd_on_cc2 == st_r.cc2_side);

    always_comb begin
        st_nxt = st_r;
        st_nxt.shutdown = shutdown_nxt;

        // Low threshold holds the switch open and the flag low until cooled
        if (thermal_threshold_low_i) begin
            st_nxt.thermal_hold = 1'b1;
        end else if (st_r.thermal_hold && thermal_cooled_i) begin
            st_nxt.thermal_hold = 1'b0;
        end

        if (!active) begin
            st_nxt.att      = tcsp_pkg::TCSP_ST_IDLE;
            st_nxt.cnt      = '0;
            st_nxt.cc2_side = 1'b0;
        end else begin
            unique case (st_r.att)
                tcsp_pkg::TCSP_ST_IDLE: begin
                    st_nxt.cnt = '0;
                    if (audio_pat) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_AUDIO;
                    end else if (debug_pat) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_DEBUG;
                    end else if (sink_pat) begin
                        st_nxt.att      = tcsp_pkg::TCSP_ST_WAIT;
                        st_nxt.cc2_side = rd_on_cc2;
                    end
                end

                tcsp_pkg::TCSP_ST_WAIT: begin
                    // Any change of side or loss of Rd restarts the attach
                    if (!sink_pat || !side_kept) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_IDLE;
                    end else if (st_r.cnt == ATT_LAST) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_SINK;
                    end else begin
                        st_nxt.cnt = st_r.cnt + AW'(1);
                    end
                end

                tcsp_pkg::TCSP_ST_SINK: begin
                    // Detach is taken at once; no deglitch on the way out
                    if (!sink_pat || !side_kept) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_IDLE;
                    end
                end

                tcsp_pkg::TCSP_ST_AUDIO: begin
                    // Detach seen on CC2 alone
                    if (!ra_on_cc2) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_IDLE;
                    end
                end

                tcsp_pkg::TCSP_ST_DEBUG: begin
                    // Detach seen on CC1 alone
                    if (cc1 != tcsp_pkg::TCSP_CC_RD) begin
                        st_nxt.att = tcsp_pkg::TCSP_ST_IDLE;
                    end
                end

                default: begin
                    st_nxt.att = tcsp_pkg::TCSP_ST_IDLE;
                end
            endcase
        end

        // Outputs, computed from the next state so they follow it directly
        st_nxt.mon       = active;
        st_nxt.main_on   = 1'b0;
        st_nxt.vc1       = 1'b0;
        st_nxt.vc2       = 1'b0;
        st_nxt.err_oe    = 1'b0;
        st_nxt.sink_oe   = 1'b0;
        st_nxt.orient_oe = 1'b0;
        st_nxt.audio_oe  = 1'b0;
        st_nxt.test_oe   = 1'b0;
        st_nxt.heavy_oe  = 1'b0;

        if (active) begin
            unique case (st_nxt.att)
                tcsp_pkg::TCSP_ST_IDLE: begin
                    // Empty or unmatched port: every attach flag stays released
                    st_nxt.sink_oe = 1'b0;
                end
                tcsp_pkg::TCSP_ST_WAIT: begin
                    // The switch stays open until the pattern has held
                    st_nxt.main_on = 1'b0;
                end
                tcsp_pkg::TCSP_ST_SINK: begin
                    st_nxt.sink_oe   = 1'b1;
                    st_nxt.orient_oe = st_nxt.cc2_side;
                    // Thermal hold and lockout keep the switch open
                    st_nxt.main_on   = !st_nxt.thermal_hold && !supply_lockout_i;
                end
                tcsp_pkg::TCSP_ST_AUDIO: begin
                    st_nxt.audio_oe = 1'b1;
                end
                tcsp_pkg::TCSP_ST_DEBUG: begin
                    st_nxt.test_oe = 1'b1;
                end
            endcase
        end

        // Cable supply goes to the Ra line facing away from the sink
        if (st_nxt.main_on) begin
            if (st_nxt.cc2_side) begin
                st_nxt.vc1 = ra_on_cc1;
            end else begin
                st_nxt.vc2 = ra_on_cc2;
            end
        end

        // Compensation only matters while load current can flow
        if (st_nxt.main_on && heavy_load_i) begin
            st_nxt.heavy_oe = 1'b1;
        end

        // Fault flag: deglitched overcurrent or low thermal threshold
        if (active && (oc_clean || st_nxt.thermal_hold)) begin
            st_nxt.err_oe = 1'b1;
        end
    end

    // Asynchronous clear releases every pin and opens every switch
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Power switches and monitor
    assign main_switch_on_o        = st_r.main_on;
    assign cable_supply_cc1_o      = st_r.vc1;
    assign cable_supply_cc2_o      = st_r.vc2;
    assign cc_monitor_on_o         = st_r.mon;

    // Open-drain pins only ever pull low; the enable decides the level seen
    // Fault
    assign error_flag_n_o          = 1'b0;
    assign error_flag_n_oe_o       = st_r.err_oe;
    // Attach and orientation
    assign sink_attached_n_o       = 1'b0;
    assign sink_attached_n_oe_o    = st_r.sink_oe;
    assign orientation_flag_n_o    = 1'b0;
    assign orientation_flag_n_oe_o = st_r.orient_oe;
    // Accessories
    assign audio_flag_n_o          = 1'b0;
    assign audio_flag_n_oe_o       = st_r.audio_oe;
    assign test_flag_n_o           = 1'b0;
    assign test_flag_n_oe_o        = st_r.test_oe;
    // Cable compensation
    assign heavy_load_n_o          = 1'b0;
    assign heavy_load_n_oe_o       = st_r.heavy_oe;

endmodule

`default_nettype wire

// File: verification/tcsp_cable_model.sv
// Far-end model: cable, sink and accessories seen as CC terminations.
// The bench picks one attach case by code; codes match its row table.
`timescale 1ns/1ns
`default_nettype none

module tcsp_cable_model (
    // Attach case chosen by the bench
    input  wire logic [3:0] attach_i,
    // Terminations seen by the port, 0 open, 1 Ra, 2 Rd
    output logic      [1:0] cc1_o,
    output logic      [1:0] cc2_o
);
    // Two bits per case, case 0 lowest; case 9 is a pattern no sink makes
    localparam logic [19:0] CC1_MAP = 20'hD9908;
    localparam logic [19:0] CC2_MAP = 20'hDA460;

    assign cc1_o = 2'(CC1_MAP >> {attach_i, 1'b0});
    assign cc2_o = 2'(CC2_MAP >> {attach_i, 1'b0});
endmodule

`default_nettype wire

// File: verification/tcsp_port_props.sv
// Checker of the port outputs against their causes.
// Bound into tcsp_port; every input has the name of a port there.
`timescale 1ns/1ns
`default_nettype none

module tcsp_port_props (
    // Clock, reset and causes
    input wire logic       mclk_i, rst_n_i, enable_i, supply_lockout_i,
    input wire logic       overcurrent_i, thermal_threshold_low_i, thermal_threshold_high_i,
    input wire logic [1:0] cc1_term_i, cc2_term_i,
    // Outputs watched
    input wire logic       main_switch_on_o, cc_monitor_on_o, error_flag_n_oe_o,
    input wire logic       cable_supply_cc1_o, cable_supply_cc2_o, sink_attached_n_oe_o,
    input wire logic       orientation_flag_n_oe_o, audio_flag_n_oe_o, test_flag_n_oe_o,
    input wire logic       heavy_load_n_oe_o
);
    logic any_oe;
    assign any_oe = error_flag_n_oe_o | sink_attached_n_oe_o | orientation_flag_n_oe_o
                  | audio_flag_n_oe_o | test_flag_n_oe_o | heavy_load_n_oe_o;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_lockout_off: assert property (supply_lockout_i |=> !main_switch_on_o)
        else $error("main switch on under lockout");
    chk_enable_off: assert property (!enable_i |=> !(any_oe | main_switch_on_o
        | cc_monitor_on_o | cable_supply_cc1_o | cable_supply_cc2_o))
        else $error("output active while disabled");
    // A fresh overcurrent must not reach the flag within two edges
    chk_oc_filter: assert property ((!error_flag_n_oe_o && !overcurrent_i) ##1
        (overcurrent_i && !thermal_threshold_low_i) |=> !error_flag_n_oe_o [*2])
        else $error("overcurrent flagged without deglitch");
    chk_thermal_hold: assert property (thermal_threshold_low_i && enable_i
        && !supply_lockout_i && !thermal_threshold_high_i
        |=> error_flag_n_oe_o && !main_switch_on_o)
        else $error("low thermal threshold not handled");
    chk_shutdown_quiet: assert property (thermal_threshold_high_i
        |=> !(any_oe | main_switch_on_o))
        else $error("output active in shutdown");
    chk_audio_release: assert property (audio_flag_n_oe_o && cc2_term_i != 2'h1
        |=> !audio_flag_n_oe_o)
        else $error("audio flag held after removal");
    chk_debug_release: assert property (test_flag_n_oe_o && cc1_term_i != 2'h2
        |=> !test_flag_n_oe_o)
        else $error("test flag held after removal");
    chk_orient_sink: assert property (orientation_flag_n_oe_o |-> sink_attached_n_oe_o)
        else $error("orientation flag without sink");
    chk_attach_steady: assert property ($rose(sink_attached_n_oe_o)
        |-> $past(cc1_term_i, 2) == $past(cc1_term_i) && $past(cc2_term_i, 2) == $past(cc2_term_i))
        else $error("sink flagged on unsteady pattern");

    cov_audio: cover property (audio_flag_n_oe_o);
    cov_orient: cover property (orientation_flag_n_oe_o);
    cov_error: cover property (error_flag_n_oe_o && main_switch_on_o);
endmodule

bind tcsp_port tcsp_port_props i_props (.*);

`default_nettype wire

// File: verification/typec_source_port_status_logic_test.sv
// Self-checking bench of tcsp_port with the cable model on its CC side.
// Short deglitch counts keep the run brief; waits are sized from them.
`timescale 1ns/1ns
`default_nettype none

module typec_source_port_status_logic_test;
    logic       mclk_i = 1'b0, rst_n_i = 1'b0, enable_i = 1'b1, supply_lockout_i = 1'b0;
    logic       overcurrent_i = 1'b0, thermal_threshold_low_i = 1'b0;
    logic       thermal_threshold_high_i = 1'b0, thermal_cooled_i = 1'b0, heavy_load_i = 1'b0;
    logic [3:0] attach = 4'h0;
    logic [1:0] cc1_term_i, cc2_term_i;
    logic       main_switch_on_o, cable_supply_cc1_o, cable_supply_cc2_o, cc_monitor_on_o;
    logic       error_flag_n_o, error_flag_n_oe_o, sink_attached_n_o, sink_attached_n_oe_o;
    logic       orientation_flag_n_o, orientation_flag_n_oe_o, audio_flag_n_o;
    logic       audio_flag_n_oe_o, test_flag_n_o, test_flag_n_oe_o;
    logic       heavy_load_n_o, heavy_load_n_oe_o;
    logic [9:0] st;
    logic [5:0] od_data;
    int         n_fail = 0;
    int         compares = 0;
    // Attach code beside main, sink, orient, audio, test, supply cc1, supply cc2
    logic [10:0] rows [10] = '{11'h000, 11'h0E0, 11'h170, 11'h180, 11'h200,
                               11'h2E1, 11'h372, 11'h384, 11'h408, 11'h480};

    tcsp_port #(.OC_DEGLITCH_CYC(4), .ATT_DEGLITCH_CYC(5)) i_dut (.*);
    tcsp_cable_model i_cable (.attach_i(attach), .cc1_o(cc1_term_i), .cc2_o(cc2_term_i));

    assign st = {error_flag_n_oe_o, heavy_load_n_oe_o, cc_monitor_on_o, main_switch_on_o,
                 sink_attached_n_oe_o, orientation_flag_n_oe_o, audio_flag_n_oe_o,
                 test_flag_n_oe_o, cable_supply_cc1_o, cable_supply_cc2_o};

    // Open-drain data pins must pull low whenever their enable is raised
    assign od_data = {error_flag_n_o, sink_attached_n_o, orientation_flag_n_o,
                      audio_flag_n_o, test_flag_n_o, heavy_load_n_o};

    always #25 mclk_i = ~mclk_i;

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Waits to the falling edge, then compares the value passed in at the call, taken before that edge's register updates; then rejoins the rising edge
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        @(negedge mclk_i);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
        @(posedge mclk_i);
    endtask

    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(50 * 3000);
        n_fail++;
        print_verdict();
    end

    initial begin
        cyc(3);
        rst_n_i <= 1'b1;
        chk("monitor", 10'h0, st);
        for (int i = 0; i < 10; i++) begin
            attach <= 4'h0;
            cyc(4);
            attach <= rows[i][10:7];
            cyc(12);
            chk("attach", {3'h1, rows[i][6:0]}, st);
        end
        attach <= 4'h0;
        cyc(4);
        attach <= 4'h8;
        cyc(4);
        attach <= 4'h3;
        cyc(2);
        chk("audio", 10'h088, st);
        attach <= 4'h4;
        cyc(2);
        chk("audio", 10'h080, st);
        attach <= 4'h7;
        cyc(4);
        attach <= 4'h1;
        cyc(2);
        chk("debug", 10'h084, st);
        attach <= 4'h2;
        cyc(2);
        chk("debug", 10'h080, st);
        attach <= 4'h1;
        cyc(12);
        heavy_load_i <= 1'b1;
        cyc(2);
        chk("heavy", 10'h1E0, st);
        heavy_load_i <= 1'b0;
        overcurrent_i <= 1'b1;
        cyc(2);
        overcurrent_i <= 1'b0;
        cyc(6);
        chk("error", 10'h0, 10'(st[9]));
        overcurrent_i <= 1'b1;
        cyc(8);
        chk("error", 10'h1, 10'(st[9]));
        chk("pins", 10'h0, 10'(od_data));
        overcurrent_i <= 1'b0;
        cyc(8);
        chk("error", 10'h0, 10'(st[9]));
        thermal_threshold_low_i <= 1'b1;
        cyc(2);
        chk("hold", 10'h2, 10'({st[9], st[6]}));
        thermal_threshold_low_i <= 1'b0;
        cyc(3);
        chk("hold", 10'h2, 10'({st[9], st[6]}));
        thermal_cooled_i <= 1'b1;
        cyc(12);
        chk("restart", 10'h1, 10'(st[6]));
        thermal_cooled_i <= 1'b0;
        thermal_threshold_high_i <= 1'b1;
        cyc(2);
        chk("shutdown", 10'h0, 10'({st[9:8], st[6:0]}));
        thermal_threshold_high_i <= 1'b0;
        thermal_cooled_i <= 1'b1;
        cyc(12);
        thermal_cooled_i <= 1'b0;
        chk("restart", 10'h0E0, st);
        enable_i <= 1'b0;
        cyc(2);
        chk("disabled", 10'h0, st);
        enable_i <= 1'b1;
        cyc(12);
        chk("enabled", 10'h0E0, st);
        supply_lockout_i <= 1'b1;
        cyc(2);
        chk("lockout", 10'h0, 10'(st[6]));
        supply_lockout_i <= 1'b0;
        cyc(12);
        chk("lockout", 10'h0E0, st);
        // Reset in mid-run with a sink attached, then a fresh attach
        rst_n_i <= 1'b0;
        cyc(2);
        chk("reset", 10'h0, st);
        rst_n_i <= 1'b1;
        cyc(12);
        chk("reattach", 10'h0E0, st);
        print_verdict();
    end
endmodule

`default_nettype wire
